// ==== pkg/pfmux_pkg.sv ====
package pfmux_pkg;

    // register indices; byte address is four times the index
    localparam logic [13:0] PFMUX_IDX_IN_EN     = 14'h28ad;
    localparam logic [13:0] PFMUX_IDX_IN_LVL    = 14'h28af;
    localparam logic [13:0] PFMUX_IDX_PLL_CTL   = 14'h28c0;
    localparam logic [13:0] PFMUX_IDX_FS0       = 14'h28c4;
    localparam logic [13:0] PFMUX_IDX_FS1       = 14'h28c5;
    localparam logic [13:0] PFMUX_IDX_FS2       = 14'h28c6;
    localparam logic [13:0] PFMUX_IDX_FS3       = 14'h28c7;
    localparam logic [13:0] PFMUX_IDX_FS4       = 14'h28c8;
    localparam logic [13:0] PFMUX_IDX_PWR_CTL   = 14'h2d00;

    // field positions and widths
    localparam int          PFMUX_NPINS         = 5;
    localparam int          PFMUX_GATE_BIT      = 3;
    localparam int          PFMUX_PLL_SEL_BIT   = 0;
    localparam int          PFMUX_FS0_W         = 2;
    localparam int          PFMUX_FS_W          = 3;

    // reset values
    localparam logic [4:0]  PFMUX_IN_EN_RST     = 5'h00;
    localparam logic [4:0]  PFMUX_IN_LVL_RST    = 5'h00;
    localparam logic [2:0]  PFMUX_FS_RST        = 3'h0;

    // function codes
    localparam logic [2:0]  PFMUX_FN_GPIO       = 3'h0;
    localparam logic [1:0]  PFMUX_FN0_SECOND    = 2'h1;
    localparam logic [2:0]  PFMUX_FN1_SER1_RX   = 3'h2;
    localparam logic [2:0]  PFMUX_FN1_TIMER1    = 3'h3;
    localparam logic [2:0]  PFMUX_FN1_IRQ2      = 3'h4;
    localparam logic [2:0]  PFMUX_FN2_SER1_TX   = 3'h2;
    localparam logic [2:0]  PFMUX_FN2_T2TRIG    = 3'h3;
    localparam logic [2:0]  PFMUX_FN2_IRQ3      = 3'h4;
    localparam logic [2:0]  PFMUX_FN3_ENERGY2   = 3'h1;
    localparam logic [2:0]  PFMUX_FN3_SER5_RX   = 3'h2;
    localparam logic [2:0]  PFMUX_FN3_IRQ0      = 3'h3;
    localparam logic [2:0]  PFMUX_FN3_ENERGY1   = 3'h4;
    localparam logic [2:0]  PFMUX_FN3_SECOND    = 3'h5;
    localparam logic [2:0]  PFMUX_FN3_PLL       = 3'h6;
    localparam logic [2:0]  PFMUX_FN4_PLL       = 3'h1;
    localparam logic [2:0]  PFMUX_FN4_SER5_TX   = 3'h2;
    localparam logic [2:0]  PFMUX_FN4_IRQ1      = 3'h3;

    // wake filter: level must hold this many oscillator cycles
    localparam logic [2:0]  PFMUX_WAKE_HOLD     = 3'h4;

    // axi responses
    localparam logic [1:0]  PFMUX_RESP_OKAY     = 2'h0;
    localparam logic [1:0]  PFMUX_RESP_SLVERR   = 2'h2;

endpackage

// ==== rtl/pfmux_top.sv ====
// Functional notes
// - enabled input levels readable, any function, except non-special pins read zero under power gate
// - input level register, bits 4:0, reset zero
// - pin0 code 01 drives second pulse
// - calibrated second pulse passed through unchanged
// - pin1 codes: serial1 rx, timer1, irq2
// - pin2 codes: serial1 tx, timer2 trigger, irq3
// - pin3 codes: energy, serial5 rx, irq0, pulses
// - pll pulse, optionally one-second width variant
// - pin4 codes: pll pulse, serial5 tx, irq1
// - input enable bits, reset disabled
// - enabled pin3/pin4 edge wakes, held four cycles
// - power gate spares pins on special functions
//
// Chosen here: register access over AXI4-Lite.
module pfmux_top
    import pfmux_pkg::*;
#(
    parameter int ADDR_W = 16
)(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic [4:0]        pin_in,
    output logic [4:0]             pin_out,
    output logic [4:0]             pin_oe,
    input  wire logic [4:0]        gpio_out_data,
    input  wire logic [4:0]        gpio_out_en,
    input  wire logic              sleep_active,
    output logic                   io_wake,
    input  wire logic              rtc_second_pulse,
    input  wire logic              serial1_transmit_out,
    input  wire logic              serial5_transmit_out,
    input  wire logic              energy_pulse_path1,
    input  wire logic              energy_pulse_path2,
    input  wire logic              divided_pll_pulse,
    input  wire logic              pll_second_pulse,
    output logic                   serial1_receive_in,
    output logic                   serial5_receive_in,
    output logic                   timer1_external_input,
    output logic                   timer2_capture_reload_trigger,
    output logic [3:0]             ext_irq_in
);

    typedef struct packed {
        logic              awready;
        logic              wready;
        logic              aw_have;
        logic              w_have;
        logic [13:0]       aw_idx;
        logic [7:0]        wbyte;
        logic              wstrb0;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
        logic [4:0]        in_en;
        logic [4:0]        in_lvl;
        logic [1:0]        fs0;
        logic [2:0]        fs1;
        logic [2:0]        fs2;
        logic [2:0]        fs3;
        logic [2:0]        fs4;
        logic              pll_sel;
        logic              pwr_gate;
        logic [1:0]        wk_prev;
        logic [1:0]        wk_filt;
        logic [1:0][2:0]   wk_cnt;
        logic              wake;
        logic [4:0]        pout;
        logic [4:0]        poe;
        logic              ser1_rx;
        logic              ser5_rx;
        logic              tim1;
        logic              t2trig;
        logic [3:0]        irq;
    } pfmux_state_t;

    pfmux_state_t q;
    pfmux_state_t d;

    logic [13:0] ar_idx;
    logic [4:0]  special;
    logic [4:0]  fn_out;
    logic [4:0]  fn_drive;
    logic        pll_pulse;
    logic        wr_fire;
    logic        wr_ok;
    logic [1:0]  wk_pin;

    assign ar_idx = s_axi_araddr[15:2];

    always_comb
    begin
        d = q;

        // write address and data are taken independently
        if (s_axi_awvalid && q.awready)
        begin
            d.aw_have = 1'b1;
            d.aw_idx  = s_axi_awaddr[15:2];
        end
        if (s_axi_wvalid && q.wready)
        begin
            d.w_have = 1'b1;
            d.wbyte  = s_axi_wdata[7:0];
            d.wstrb0 = s_axi_wstrb[0];
        end
        if (s_axi_bvalid && s_axi_bready)
        begin
            d.bvalid = 1'b0;
        end

        wr_fire = q.aw_have && q.w_have && !q.bvalid;
        wr_ok   = 1'b1;
        if (wr_fire)
        begin
            d.aw_have = 1'b0;
            d.w_have  = 1'b0;
            d.bvalid  = 1'b1;
            unique case (q.aw_idx)
                PFMUX_IDX_IN_EN:
                    if (q.wstrb0) d.in_en = q.wbyte[4:0];
                PFMUX_IDX_IN_LVL: ;
                PFMUX_IDX_PLL_CTL:
                    if (q.wstrb0) d.pll_sel = q.wbyte[PFMUX_PLL_SEL_BIT];
                PFMUX_IDX_FS0:
                    if (q.wstrb0) d.fs0 = q.wbyte[PFMUX_FS0_W-1:0];
                PFMUX_IDX_FS1:
                    if (q.wstrb0) d.fs1 = q.wbyte[PFMUX_FS_W-1:0];
                PFMUX_IDX_FS2:
                    if (q.wstrb0) d.fs2 = q.wbyte[PFMUX_FS_W-1:0];
                PFMUX_IDX_FS3:
                    if (q.wstrb0) d.fs3 = q.wbyte[PFMUX_FS_W-1:0];
                PFMUX_IDX_FS4:
                    if (q.wstrb0) d.fs4 = q.wbyte[PFMUX_FS_W-1:0];
                PFMUX_IDX_PWR_CTL:
                    if (q.wstrb0) d.pwr_gate = q.wbyte[PFMUX_GATE_BIT];
                default:
                    wr_ok = 1'b0;
            endcase
            d.bresp = wr_ok ? PFMUX_RESP_OKAY : PFMUX_RESP_SLVERR;
        end
        d.awready = !d.aw_have && !d.bvalid;
        d.wready  = !d.w_have && !d.bvalid;

        // read channel
        if (s_axi_rvalid && s_axi_rready)
        begin
            d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && q.arready)
        begin
            d.rvalid = 1'b1;
            d.rdata  = 32'h0000_0000;
            d.rresp  = PFMUX_RESP_OKAY;
            unique case (ar_idx)
                PFMUX_IDX_IN_EN:   d.rdata[4:0] = q.in_en;
                PFMUX_IDX_IN_LVL:  d.rdata[4:0] = q.in_lvl;
                PFMUX_IDX_PLL_CTL: d.rdata[PFMUX_PLL_SEL_BIT] = q.pll_sel;
                PFMUX_IDX_FS0:     d.rdata[PFMUX_FS0_W-1:0] = q.fs0;
                PFMUX_IDX_FS1:     d.rdata[PFMUX_FS_W-1:0] = q.fs1;
                PFMUX_IDX_FS2:     d.rdata[PFMUX_FS_W-1:0] = q.fs2;
                PFMUX_IDX_FS3:     d.rdata[PFMUX_FS_W-1:0] = q.fs3;
                PFMUX_IDX_FS4:     d.rdata[PFMUX_FS_W-1:0] = q.fs4;
                PFMUX_IDX_PWR_CTL: d.rdata[PFMUX_GATE_BIT] = q.pwr_gate;
                default:           d.rresp = PFMUX_RESP_SLVERR;
            endcase
        end
        d.arready = !d.rvalid;

        // a pin counts as special only for a legal non-gpio code
        special[0] = (q.fs0 == PFMUX_FN0_SECOND);
        special[1] = (q.fs1 == PFMUX_FN1_SER1_RX) || (q.fs1 == PFMUX_FN1_TIMER1)
                     || (q.fs1 == PFMUX_FN1_IRQ2);
        special[2] = (q.fs2 == PFMUX_FN2_SER1_TX) || (q.fs2 == PFMUX_FN2_T2TRIG)
                     || (q.fs2 == PFMUX_FN2_IRQ3);
        special[3] = (q.fs3 != PFMUX_FN_GPIO) && (q.fs3 <= PFMUX_FN3_PLL);
        special[4] = (q.fs4 != PFMUX_FN_GPIO) && (q.fs4 <= PFMUX_FN4_IRQ1);

        // pll output variant chosen by software
        pll_pulse = q.pll_sel ? pll_second_pulse : divided_pll_pulse;

        // peripheral outputs that take over pins
        fn_drive = 5'h00;
        fn_out   = 5'h00;
        if (q.fs0 == PFMUX_FN0_SECOND)
        begin
            fn_drive[0] = 1'b1;
            fn_out[0]   = rtc_second_pulse;
        end
        if (q.fs2 == PFMUX_FN2_SER1_TX)
        begin
            fn_drive[2] = 1'b1;
            fn_out[2]   = serial1_transmit_out;
        end
        unique case (q.fs3)
            PFMUX_FN3_ENERGY2:
            begin
                fn_drive[3] = 1'b1;
                fn_out[3]   = energy_pulse_path2;
            end
            PFMUX_FN3_ENERGY1:
            begin
                fn_drive[3] = 1'b1;
                fn_out[3]   = energy_pulse_path1;
            end
            PFMUX_FN3_SECOND:
            begin
                fn_drive[3] = 1'b1;
                fn_out[3]   = rtc_second_pulse;
            end
            PFMUX_FN3_PLL:
            begin
                fn_drive[3] = 1'b1;
                fn_out[3]   = pll_pulse;
            end
            default: ;
        endcase
        unique case (q.fs4)
            PFMUX_FN4_PLL:
            begin
                fn_drive[4] = 1'b1;
                fn_out[4]   = pll_pulse;
            end
            PFMUX_FN4_SER5_TX:
            begin
                fn_drive[4] = 1'b1;
                fn_out[4]   = serial5_transmit_out;
            end
            default: ;
        endcase

        // pin drive: function wins, else gated gpio
        for (int i = 0; i < PFMUX_NPINS; i++)
        begin
            if (fn_drive[i])
            begin
                d.pout[i] = fn_out[i];
                d.poe[i]  = 1'b1;
            end
            else
            begin
                d.pout[i] = gpio_out_data[i];
                d.poe[i]  = gpio_out_en[i] && !(q.pwr_gate && !special[i]);
            end
            // enabled input mirrors pin level for any function, except a non-special pin reads zero under power gate
            d.in_lvl[i] = pin_in[i] && q.in_en[i]
                          && !(q.pwr_gate && !special[i]);
        end

        // pin levels routed to input peripherals; idle levels otherwise
        d.ser1_rx = (q.fs1 == PFMUX_FN1_SER1_RX) ? pin_in[1] : 1'b1;
        d.tim1    = (q.fs1 == PFMUX_FN1_TIMER1) && pin_in[1];
        d.irq[2]  = (q.fs1 == PFMUX_FN1_IRQ2) && pin_in[1];
        d.t2trig  = (q.fs2 == PFMUX_FN2_T2TRIG) && pin_in[2];
        d.irq[3]  = (q.fs2 == PFMUX_FN2_IRQ3) && pin_in[2];
        d.ser5_rx = (q.fs3 == PFMUX_FN3_SER5_RX) ? pin_in[3] : 1'b1;
        d.irq[0]  = (q.fs3 == PFMUX_FN3_IRQ0) && pin_in[3];
        d.irq[1]  = (q.fs4 == PFMUX_FN4_IRQ1) && pin_in[4];

        // wake on a filtered level change of enabled pins 3 and 4
        wk_pin = pin_in[4:3];
        d.wake = 1'b0;
        for (int k = 0; k < 2; k++)
        begin
            d.wk_prev[k] = wk_pin[k];
            if (wk_pin[k] != q.wk_prev[k])
            begin
                d.wk_cnt[k] = 3'h1;
            end
            else if (q.wk_cnt[k] < PFMUX_WAKE_HOLD)
            begin
                d.wk_cnt[k] = q.wk_cnt[k] + 3'h1;
            end
            if (d.wk_cnt[k] >= PFMUX_WAKE_HOLD && q.wk_prev[k] != q.wk_filt[k])
            begin
                d.wk_filt[k] = q.wk_prev[k];
                if (sleep_active && q.in_en[k+3])
                begin
                    d.wake = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q        <= '0;
            q.in_en  <= PFMUX_IN_EN_RST;
            q.in_lvl <= PFMUX_IN_LVL_RST;
            q.fs1    <= PFMUX_FS_RST;
            q.ser1_rx <= 1'b1;
            q.ser5_rx <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    assign s_axi_awready                 = q.awready;
    assign s_axi_wready                  = q.wready;
    assign s_axi_bresp                   = q.bresp;
    assign s_axi_bvalid                  = q.bvalid;
    assign s_axi_arready                 = q.arready;
    assign s_axi_rdata                   = q.rdata;
    assign s_axi_rresp                   = q.rresp;
    assign s_axi_rvalid                  = q.rvalid;
    assign pin_out                       = q.pout;
    assign pin_oe                        = q.poe;
    assign io_wake                       = q.wake;
    assign serial1_receive_in            = q.ser1_rx;
    assign serial5_receive_in            = q.ser5_rx;
    assign timer1_external_input         = q.tim1;
    assign timer2_capture_reload_trigger = q.t2trig;
    assign ext_irq_in                    = q.irq;

endmodule // pfmux_top

// ==== testbench/pfmux_props.sv ====
module pfmux_props (
    input logic        aclk,
    input logic        aresetn,
    input logic        s_axi_awvalid,
    input logic        s_axi_awready,
    input logic        s_axi_wvalid,
    input logic        s_axi_wready,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic [1:0]  s_axi_bresp,
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic [31:0] s_axi_rdata,
    input logic        sleep_active,
    input logic        io_wake
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_write_answer:
        assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer late or early");
    a_bvalid_hold:
        assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_read_answer:
        assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer missing");
    a_rvalid_hold:
        assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_ar_blocked:
        assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
    a_rdata_upper:
        assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_wake_pulse:
        assert property (io_wake |=> !io_wake) else $error("wake longer than one cycle");
    a_wake_sleep:
        assert property (io_wake |-> $past(sleep_active)) else $error("wake outside sleep");
endmodule // pfmux_props

bind pfmux_top pfmux_props pfmux_props_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .sleep_active(sleep_active), .io_wake(io_wake));

// ==== testbench/pfmux_top_tb.sv ====
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
    $display("mismatch at %0t: got %0h exp %0h", $time, a, b); end end
module pfmux_top_tb
    import pfmux_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk = 1'b0, aresetn = 1'b0, sleep_active = 1'b0, io_wake;
    logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0, e;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf, irq;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [4:0]  pin_in = 5'h1f, gpio_out_data = 5'h0, gpio_out_en = 5'h1f, pin_out, pin_oe;
    logic [6:0]  src = 7'h0;
    logic        s1rx, s5rx, t1in, t2in;
    logic [7:0]  obs, exp;
    logic [13:0] fs;
    int          error_cnt = 0, tests_run = 0, cyc = 0, wakes = 0;
    // kind, pin, code, observed bit: kind 0 output, 1 input, 2 reserved
    logic [15:0] tbl [23] = '{16'h0010, 16'h0221, 16'h0314, 16'h0343, 16'h0350, 16'h0365,
        16'h0415, 16'h0422, 16'h0366, 16'h1120, 16'h1132, 16'h1146, 16'h1233, 16'h1247,
        16'h1321, 16'h1334, 16'h1435, 16'h2020, 16'h2110, 16'h2210, 16'h2370, 16'h2440,
        16'h2150};
    assign obs = {irq, t2in, t1in, s5rx, s1rx};

    pfmux_top pfmux_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .gpio_out_data(gpio_out_data), .gpio_out_en(gpio_out_en),
        .sleep_active(sleep_active), .io_wake(io_wake), .rtc_second_pulse(src[0]),
        .serial1_transmit_out(src[1]), .serial5_transmit_out(src[2]),
        .energy_pulse_path1(src[3]), .energy_pulse_path2(src[4]), .divided_pll_pulse(src[5]),
        .pll_second_pulse(src[6]), .serial1_receive_in(s1rx), .serial5_receive_in(s5rx),
        .timer1_external_input(t1in), .timer2_capture_reload_trigger(t2in), .ext_irq_in(irq));

    always #5 aclk = ~aclk;

    always @(posedge aclk)
    begin
        cyc++;
        if (io_wake !== 1'b0) wakes++;
        if (cyc == 5000)
        begin
            error_cnt++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("counts: tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic wr(input logic [13:0] idx, input logic [31:0] d, input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done)
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            done = s_axi_bvalid;
        end
        s_axi_bready <= 1'b0;
        `CHK(s_axi_bresp, er)
    endtask

    task automatic rd_chk(input logic [13:0] idx, input logic [31:0] x, input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done)
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            done = s_axi_rvalid;
        end
        s_axi_rready <= 1'b0;
        `CHK(s_axi_rdata, x)
        `CHK(s_axi_rresp, er)
    endtask

    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 5; i++)
            rd_chk(PFMUX_IDX_FS0 + 14'(i), 32'h0, PFMUX_RESP_OKAY);
        rd_chk(PFMUX_IDX_IN_EN, 32'h0, PFMUX_RESP_OKAY);
        rd_chk(PFMUX_IDX_IN_LVL, 32'h0, PFMUX_RESP_OKAY);
        $display("test reset_values done");
        wr(PFMUX_IDX_IN_EN, 32'h05, PFMUX_RESP_OKAY);
        rd_chk(PFMUX_IDX_IN_LVL, 32'h05, PFMUX_RESP_OKAY);
        wr(PFMUX_IDX_IN_LVL, 32'h1a, PFMUX_RESP_OKAY);
        rd_chk(PFMUX_IDX_IN_LVL, 32'h05, PFMUX_RESP_OKAY);
        wr(PFMUX_IDX_IN_EN, 32'h00, PFMUX_RESP_OKAY);
        rd_chk(PFMUX_IDX_IN_LVL, 32'h00, PFMUX_RESP_OKAY);
        wr(14'h0100, 32'h1, PFMUX_RESP_SLVERR);
        rd_chk(14'h0100, 32'h0, PFMUX_RESP_SLVERR);
        s_axi_wstrb <= 4'h0;
        wr(PFMUX_IDX_FS1, 32'h2, PFMUX_RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        rd_chk(PFMUX_IDX_FS1, 32'h0, PFMUX_RESP_OKAY);
        $display("test input_levels done");
        pin_in <= 5'h00;
        for (int i = 0; i < 23; i++)
        begin
            e = tbl[i];
            fs = PFMUX_IDX_FS0 + 14'(e[11:8]);
            if (e[3:0] == 4'h6) wr(PFMUX_IDX_PLL_CTL, 32'h1, PFMUX_RESP_OKAY);
            wr(fs, 32'(e[7:4]), PFMUX_RESP_OKAY);
            rd_chk(fs, 32'(e[7:4]), PFMUX_RESP_OKAY);
            for (int v = 0; v < 2; v++)
            begin
                src <= (e[15:12] == 4'h0) ? 7'(v) << e[3:0] : 7'h0;
                pin_in <= 5'(v) << e[11:8];
                gpio_out_data <= (e[15:12] == 4'h0) ? {5{v == 0}} : {5{v == 1}};
                gpio_out_en <= {5{v == 1}};
                repeat (3) @(posedge aclk);
                #1;
                exp = (e[15:12] != 4'h1) ? 8'h03 : v ? 8'h03 | (8'h01 << e[3:0])
                    : 8'h03 & ~(8'h01 << e[3:0]);
                `CHK(obs, exp)
                if (e[15:12] != 4'h1)
                begin
                    `CHK(pin_out[e[11:8]], 1'(v))
                    `CHK(pin_oe[e[11:8]], (e[15:12] == 4'h0) ? 1'b1 : 1'(v))
                end
            end
            wr(fs, 32'h0, PFMUX_RESP_OKAY);
            if (e[3:0] == 4'h6) wr(PFMUX_IDX_PLL_CTL, 32'h0, PFMUX_RESP_OKAY);
        end
        $display("test function_table done");
        pin_in <= 5'h1f;
        wr(PFMUX_IDX_IN_EN, 32'h1f, PFMUX_RESP_OKAY);
        wr(PFMUX_IDX_FS3, 32'h6, PFMUX_RESP_OKAY);
        wr(PFMUX_IDX_PWR_CTL, 32'h08, PFMUX_RESP_OKAY);
        rd_chk(PFMUX_IDX_IN_LVL, 32'h08, PFMUX_RESP_OKAY);
        `CHK(pin_oe, 5'h08)
        wr(PFMUX_IDX_PWR_CTL, 32'h0, PFMUX_RESP_OKAY);
        wr(PFMUX_IDX_FS3, 32'h0, PFMUX_RESP_OKAY);
        $display("test power_gate done");
        wr(PFMUX_IDX_IN_EN, 32'h18, PFMUX_RESP_OKAY);
        pin_in <= 5'h00;
        sleep_active <= 1'b1;
        repeat (10) @(posedge aclk);
        wakes = 0;
        pin_in <= 5'h08;
        repeat (2) @(posedge aclk);
        pin_in <= 5'h00;
        repeat (20) @(posedge aclk);
        `CHK(wakes, 0)
        pin_in <= 5'h10;
        repeat (20) @(posedge aclk);
        `CHK(wakes, 1)
        $display("test wake done");
        wrap_up();
    end
endmodule // pfmux_top_tb
